/* rtl/lhrp_device.sv */
/*
  device end: sixteen byte registers behind a strobed parallel port.
  assumes host pins are asynchronous and pass two flip-flops here.
*/
// Contract
// RQ1 - reply low on select with either strobe
// RQ2 - select plus write stores byte at address
// RQ3 - select plus read drives addressed register
// RQ4 - strobes without select do nothing
// RQ5 - master reset clears all, two flags set
// RQ6 - grant stable before master reset release
// RQ7 - eight bit shared three-state data bus
// RQ8 - four address lines select sixteen registers
// RQ9 - bus released except during selected read
`timescale 1ns/1ps
`include "lhrp_cfg.svh"

module lhrp_device
  import lhrp_pkg::*;
#(
  parameter int NUM_REGS = `LHRP_NUM_REGS
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  lhrp_if.device     pins,
  output lhrp_byte_t ctrl_reg,
  output logic       dma_grant_level
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  localparam int         AW        = `LHRP_ADDR_W;
  localparam int         DW        = `LHRP_DATA_W;
  localparam int         DISC_BIT  = `LHRP_DISC_BIT;
  localparam int         SCF_BIT   = `LHRP_SCF_BIT;
  localparam lhrp_byte_t REG_INIT  = `LHRP_REG_RESET;
  localparam lhrp_byte_t CTRL_INIT = `LHRP_CTRL_RESET;

  if (NUM_REGS < 1 || NUM_REGS > `LHRP_NUM_REGS) begin : g_chk_regs
    $error("NUM_REGS out of range");
  end
  if (NUM_REGS > (1 << AW)) begin : g_chk_reach
    $error("NUM_REGS beyond address reach");
  end
  if (int'(`LHRP_CTRL_ADDR) >= NUM_REGS) begin : g_chk_ctrl
    $error("control register outside the file");
  end
  if (DISC_BIT >= DW || SCF_BIT >= DW) begin : g_chk_flags
    $error("flag position outside the byte");
  end
  if (!CTRL_INIT[DISC_BIT] || !CTRL_INIT[SCF_BIT]) begin : g_chk_init
    $error("both flags must be set at reset"); // RQ5
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       cs_n;
    logic       we_n;
    logic       rd_n;
    logic       mreset_n;
    logic       grant_n;
    lhrp_addr_t addr;
    lhrp_byte_t data;
  } lhrp_pin_set_t;

  lhrp_pin_set_t pin_now;
  lhrp_pin_set_t s1_r;
  lhrp_pin_set_t s2_r;
  logic          cs_n;
  logic          we_n;
  logic          rd_n;
  logic          mreset_n;
  logic          grant_n;
  lhrp_addr_t    addr;
  lhrp_byte_t    din;

  // raw pins gathered into one word
  always_comb begin
    pin_now.cs_n     = pins.chip_select_n;
    pin_now.we_n     = pins.write_strobe_n;
    pin_now.rd_n     = pins.output_strobe_n;
    pin_now.mreset_n = pins.master_reset_n;
    pin_now.grant_n  = pins.dma_grant_n;
    pin_now.addr     = pins.reg_addr;
    pin_now.data     = pins.parallel_bus;
  end

  // two flops before any logic reads a pin; idle level is high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= '1;
      s2_r <= '1;
    end else begin
      s1_r <= pin_now;
      s2_r <= s1_r;
    end
  end

  assign cs_n     = s2_r.cs_n;
  assign we_n     = s2_r.we_n;
  assign rd_n     = s2_r.rd_n;
  assign mreset_n = s2_r.mreset_n;
  assign grant_n  = s2_r.grant_n;
  assign addr     = s2_r.addr;
  assign din      = s2_r.data;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic wr_req;
  logic rd_req;
  logic addr_ok;

  assign wr_req  = !cs_n && !we_n; // RQ2 RQ4
  assign rd_req  = !cs_n && !rd_n; // RQ3 RQ4
  assign addr_ok = 32'(addr) < NUM_REGS; // RQ8

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  lhrp_state_t st_r;
  lhrp_state_t st_nxt;

  // a strobe must go high again before the next access starts
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      LHRP_IDLE: begin
        if (wr_req) st_nxt = LHRP_WRITE;
        else if (rd_req) st_nxt = LHRP_READ;
      end
      LHRP_WRITE: if (!wr_req) st_nxt = LHRP_IDLE;
      LHRP_READ:  if (!rd_req) st_nxt = LHRP_IDLE;
      default:    st_nxt = LHRP_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !mreset_n) st_r <= LHRP_IDLE;
    else st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  lhrp_byte_t regs_r [NUM_REGS];
  logic       wr_en;
  lhrp_byte_t rd_mux;

  // one store per strobe, taken on the way out of idle
  assign wr_en = (st_r == LHRP_IDLE) && wr_req && addr_ok; // RQ2

  always_ff @(posedge clk) begin
    if (!rst_n || !mreset_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= REG_INIT; // RQ5
      end
      regs_r[`LHRP_CTRL_ADDR] <= CTRL_INIT; // RQ5
    end else if (wr_en) begin
      regs_r[addr] <= din; // RQ2
    end
  end

  // unmapped locations read as zero
  always_comb begin
    rd_mux = REG_INIT;
    if (addr_ok) rd_mux = regs_r[addr]; // RQ3 RQ8
  end

  // ----------------------------------------------------------------
  // reply and read data
  // ----------------------------------------------------------------
  lhrp_byte_t dout_r;
  logic       oe_n_r;
  logic       reply_n_r;

  always_ff @(posedge clk) begin
    if (!rst_n || !mreset_n) dout_r <= REG_INIT;
    else dout_r <= rd_mux; // RQ3
  end

  // bus released unless a selected read is seen
  always_ff @(posedge clk) begin
    if (!rst_n || !mreset_n) oe_n_r <= 1'b1;
    else oe_n_r <= !rd_req; // RQ9 RQ7
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !mreset_n) reply_n_r <= 1'b1;
    else reply_n_r <= !(wr_req || rd_req); // RQ1
  end

  // ----------------------------------------------------------------
  // grant capture
  // ----------------------------------------------------------------
  logic mreset_q_r;
  logic grant_r;

  // starts at the idle level, so leaving rst_n is no edge
  always_ff @(posedge clk) begin
    if (!rst_n) mreset_q_r <= 1'b1;
    else mreset_q_r <= mreset_n;
  end

  // grant level taken on master reset release
  always_ff @(posedge clk) begin
    if (!rst_n) grant_r <= 1'b0;
    else if (mreset_n && !mreset_q_r) grant_r <= !grant_n; // RQ6
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pins.bus_from_dev = dout_r;
  assign pins.dev_oe_n     = oe_n_r;
  assign pins.reply_n      = reply_n_r;
  assign ctrl_reg          = regs_r[`LHRP_CTRL_ADDR];
  assign dma_grant_level   = grant_r;

endmodule

/* shared/lhrp_cfg.svh */
/*
  constants for the host register port of the serial link controller.
  assumes inclusion by bare name from the package and both ends.
*/
`ifndef LHRP_CFG_SVH
`define LHRP_CFG_SVH

`define LHRP_DATA_W      8
`define LHRP_ADDR_W      4
`define LHRP_NUM_REGS    16
`define LHRP_REG_RESET   8'h00
// control register holding the two flags set at reset
`define LHRP_CTRL_ADDR   4'h0
`define LHRP_DISC_BIT    0
`define LHRP_SCF_BIT     1
`define LHRP_CTRL_RESET  8'h03
`define LHRP_BUS_IDLE    8'hFF

`endif

/* shared/lhrp_pkg.sv */
/*
  types shared by both ends of the host register port.
  assumes lhrp_cfg.svh on the include path.
*/
`include "lhrp_cfg.svh"

package lhrp_pkg;
  typedef logic [`LHRP_DATA_W-1:0] lhrp_byte_t;
  typedef logic [`LHRP_ADDR_W-1:0] lhrp_addr_t;
  typedef enum logic [2:0] {
    LHRP_IDLE  = 3'b001,
    LHRP_WRITE = 3'b010,
    LHRP_READ  = 3'b100
  } lhrp_state_t;
endpackage

/* shared/lhrp_if.sv */
/*
  pin bundle joining host and device of the register port.
  resolves the shared bus here from the enables; the device end wins over the host end.
*/
`timescale 1ns/1ps
`include "lhrp_cfg.svh"

interface lhrp_if;
  logic                    chip_select_n;
  logic                    write_strobe_n;
  logic                    output_strobe_n;
  logic [`LHRP_ADDR_W-1:0] reg_addr;
  logic                    reply_n;
  logic                    dma_grant_n;
  logic                    master_reset_n;
  logic [`LHRP_DATA_W-1:0] bus_from_host;
  logic                    host_oe_n;
  logic [`LHRP_DATA_W-1:0] bus_from_dev;
  logic                    dev_oe_n;
  logic [`LHRP_DATA_W-1:0] parallel_bus;

  // resolved bus level; idle pulls high
  assign parallel_bus = !dev_oe_n  ? bus_from_dev  :
                        !host_oe_n ? bus_from_host : `LHRP_BUS_IDLE;

  modport device (
    input  chip_select_n, write_strobe_n, output_strobe_n, reg_addr,
    input  dma_grant_n, master_reset_n, parallel_bus,
    output reply_n, bus_from_dev, dev_oe_n
  );
  modport host (
    input  reply_n, parallel_bus,
    output chip_select_n, write_strobe_n, output_strobe_n, reg_addr,
    output dma_grant_n, master_reset_n, bus_from_host, host_oe_n
  );
endinterface

/* rtl/lhrp_host.sv */
/*
  host end: runs one register read or write per request.
  assumes reply_n comes from the device clock domain via two flops.
*/
`timescale 1ns/1ps
`include "lhrp_cfg.svh"

module lhrp_host
  import lhrp_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  lhrp_if.host       pins,
  input  wire logic  req,
  input  wire logic  req_write,
  input  lhrp_addr_t req_addr,
  input  lhrp_byte_t req_wdata,
  input  wire logic  dev_reset_n,
  input  wire logic  dma_grant_n,
  output logic       busy,
  output logic       done,
  output lhrp_byte_t rdata
);

  // ----------------------------------------------------------------
  // reply synchroniser
  // ----------------------------------------------------------------
  logic rp1_r;
  logic rp2_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rp1_r <= 1'b1;
      rp2_r <= 1'b1;
    end else begin
      rp1_r <= pins.reply_n;
      rp2_r <= rp1_r;
    end
  end

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  lhrp_state_t st_r;
  logic        wr_r;
  lhrp_addr_t  addr_r;
  lhrp_byte_t  wdata_r;
  lhrp_byte_t  rdata_r;
  logic        done_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r    <= LHRP_IDLE;
      wr_r    <= 1'b0;
      addr_r  <= '0;
      wdata_r <= '0;
      rdata_r <= '0;
      done_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        // previous reply must clear before a new access
        LHRP_IDLE: if (req && rp2_r) begin // RQ1
          wr_r    <= req_write;
          addr_r  <= req_addr; // RQ8
          wdata_r <= req_wdata;
          st_r    <= req_write ? LHRP_WRITE : LHRP_READ;
        end
        LHRP_WRITE, LHRP_READ: if (!rp2_r) begin
          if (!wr_r) rdata_r <= pins.parallel_bus; // RQ3
          done_r <= 1'b1;
          st_r   <= LHRP_IDLE;
        end
        default: st_r <= LHRP_IDLE;
      endcase
    end
  end

  // select held throughout every access
  assign pins.chip_select_n   = (st_r == LHRP_IDLE); // RQ4
  assign pins.write_strobe_n  = (st_r != LHRP_WRITE); // RQ2
  assign pins.output_strobe_n = (st_r != LHRP_READ); // RQ3
  assign pins.reg_addr        = addr_r;
  assign pins.bus_from_host   = wdata_r;
  assign pins.host_oe_n       = (st_r != LHRP_WRITE); // RQ7
  assign pins.master_reset_n  = dev_reset_n; // RQ5
  assign pins.dma_grant_n     = dma_grant_n; // RQ6
  assign busy  = (st_r != LHRP_IDLE) || !rp2_r;
  assign done  = done_r;
  assign rdata = rdata_r;

endmodule

/* dv/lhrp_port_sva.sv */
/*
  timing checks on the pins between host and device ends.
  assumes the bench instantiates it beside the interface.
*/
`timescale 1ns/1ps
module lhrp_port_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_strobe_n,
  input wire logic reply_n,
  input wire logic dev_oe_n,
  input wire logic host_oe_n,
  input wire logic master_reset_n
);
  logic sel;
  logic rd;
  assign rd  = !chip_select_n && !output_strobe_n;
  assign sel = rd || (!chip_select_n && !write_strobe_n);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence sel_s; sel; endsequence
  sequence rd_s; rd; endsequence
  reply_low_a: assert property (sel_s [*4] |-> !reply_n)
    else $error("reply missing on access");
  reply_cause_a: assert property ($fell(reply_n) |-> $past(sel, 3))
    else $error("reply without select and strobe");
  reply_hold_a: assert property (sel && !reply_n |=> !reply_n)
    else $error("reply dropped during access");
  read_drive_a: assert property (rd_s [*4] |-> !dev_oe_n)
    else $error("bus not driven on read");
  bus_release_a: assert property (!dev_oe_n |-> $past(rd, 3))
    else $error("bus driven outside read");
  bus_clash_a: assert property (!(!dev_oe_n && !host_oe_n))
    else $error("both ends drive the bus");
  reset_idle_a: assert property (disable iff (1'b0)
    !rst_n |=> reply_n && dev_oe_n) else $error("reset left port busy");
  mreset_idle_a: assert property (!master_reset_n [*4]
    |-> reply_n && dev_oe_n) else $error("master reset left port busy");
endmodule

/* dv/lapb_host_register_port_test.sv */
/*
  self-checking bench: host end drives device end through the pins.
  assumes both design ends and the shared interface are compiled.
*/
`timescale 1ns/1ps
module lapb_host_register_port_test;
  import lhrp_pkg::*;
  logic       clk, rst_n, req, req_write, dev_reset_n, dma_grant_n;
  logic       busy, done, dma_grant_level;
  lhrp_addr_t req_addr;
  lhrp_byte_t req_wdata, rdata, ctrl_reg;
  int         num_errors = 0, check_count = 0, cycles = 0;
  lhrp_if u_if ();
  lhrp_device i_lhrp_device (.clk(clk), .rst_n(rst_n), .pins(u_if),
    .ctrl_reg(ctrl_reg), .dma_grant_level(dma_grant_level));
  lhrp_host i_lhrp_host (.clk(clk), .rst_n(rst_n), .pins(u_if),
    .req(req), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .dev_reset_n(dev_reset_n),
    .dma_grant_n(dma_grant_n), .busy(busy), .done(done), .rdata(rdata));
  lhrp_port_sva i_lhrp_port_sva (.clk(clk), .rst_n(rst_n),
    .chip_select_n(u_if.chip_select_n),
    .write_strobe_n(u_if.write_strobe_n),
    .output_strobe_n(u_if.output_strobe_n), .reply_n(u_if.reply_n),
    .dev_oe_n(u_if.dev_oe_n), .host_oe_n(u_if.host_oe_n),
    .master_reset_n(u_if.master_reset_n));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(string what, lhrp_byte_t exp, lhrp_byte_t got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic access(logic wr, lhrp_addr_t a, lhrp_byte_t d);
    int n = 0;
    @(negedge clk);
    while (busy !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    req = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(negedge clk);
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    cmp("done", 8'h01, {7'h00, done});
  endtask
  task automatic rd_chk(lhrp_addr_t a, lhrp_byte_t exp);
    access(1'b0, a, 8'h00);
    cmp("rdata", exp, rdata);
  endtask
  task automatic idle_chk();
    repeat (8) @(negedge clk);
    cmp("idle bus", 8'hFF, u_if.parallel_bus);
    cmp("idle reply", 8'h01, {7'h00, u_if.reply_n});
    cmp("busy", 8'h00, {7'h00, busy});
  endtask
  task automatic mreset_chk(logic grant_n, lhrp_byte_t exp);
    dma_grant_n = grant_n;
    repeat (4) @(negedge clk);
    dev_reset_n = 1'b0;
    repeat (8) @(negedge clk);
    dev_reset_n = 1'b1;
    repeat (8) @(negedge clk);
    cmp("grant", exp, {7'h00, dma_grant_level});
  endtask
  // ----------------------------------------
  // clock, timeout and sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    req = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    dev_reset_n = 1'b1;
    dma_grant_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    idle_chk();
    cmp("ctrl_reg", 8'h03, ctrl_reg);
    for (int i = 0; i < 16; i++) begin
      rd_chk(i[3:0], (i == 0) ? 8'h03 : 8'h00);
    end
    for (int i = 0; i < 16; i++) begin
      access(1'b1, i[3:0], 8'h5A ^ i[7:0]);
    end
    for (int i = 15; i >= 0; i--) begin
      rd_chk(i[3:0], 8'h5A ^ i[7:0]);
    end
    cmp("ctrl_reg", 8'h5A, ctrl_reg);
    idle_chk();
    mreset_chk(1'b0, 8'h01);
    rd_chk(4'h0, 8'h03);
    rd_chk(4'hF, 8'h00);
    mreset_chk(1'b1, 8'h00);
    idle_chk();
    end_of_test();
  end
endmodule
